// *** design/monitor_regs.v ***
// Register side of the hardware monitor: wide register access, resets, address, scan, error banks
//
// Chosen here: the placing of the registers and register access over APB.
`include "monitor_map.vh"

module monitor_regs #(
    parameter PASS_CYCLES = `PASS_CYC,
    parameter EXT_CYCLES  = `EXT_RESET_CYC,
    parameter POR_CYCLES  = `POR_PULSE_CYC,
    parameter NUM_WIDE    = `NUM_WIDE
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        reset_pin_in,
    output reg         reset_pin_out,
    output reg         reset_pin_oe,
    input  wire [1:0]  addr_strap,
    input  wire [7:0]  bmc_event,
    input  wire [7:0]  host_event,
    input  wire [7:0]  conv_data,
    input  wire        diode_1b_en,
    input  wire        diode_2b_en,
    output reg  [4:0]  conv_channel,
    output reg         conv_start
);
    // =============================================================
    // Bus decode
    wire        acc      = psel & ~penable;
    wire        wr_acc   = acc & pwrite;
    wire        rd_acc   = acc & ~pwrite;
    wire [11:0] off      = paddr;

    reg  [31:0] ctrl;
    reg  [7:0]  sleep_ctrl;
    reg  [7:0]  limit_reg;
    reg  [7:0]  setup_reg;
    reg  [7:0]  sleep_mask;
    reg  [7:0]  other_mask;
    reg  [7:0]  factory_reg;
    reg  [1:0]  wide_sel;
    reg  [15:0] wide_val [0:NUM_WIDE-1];
    reg  [7:0]  frozen_hi;
    reg  [1:0]  frozen_idx;
    reg         frozen;
    reg  [7:0]  pend_lo;
    reg  [1:0]  pend_idx;
    reg         pend;
    reg         nack;
    reg  [6:0]  slave_addr;
    reg         addr_fixed;
    reg         por_active;
    reg         por_done;
    reg  [15:0] por_cnt;
    reg  [15:0] ext_cnt;
    reg         ext_done;
    reg  [31:0] pass_cnt;
    reg  [7:0]  conv_val [0:`NUM_CHANNELS-1];
    reg  [1:0]  strap_s1;
    reg  [1:0]  strap_s2;
    reg  [1:0]  acc_pipe;

    wire        pin_level;
    wire        pin_fall;
    wire [7:0]  bmc_flags;
    wire [7:0]  host_flags;
    wire        lock = ctrl[`CTRL_LOCK_BIT];
    wire        cfg_wr = wr_acc & ~lock;

    // =============================================================
    // Reset pin synchroniser
    edge_sync u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (reset_pin_in),
        .level   (pin_level),
        .rise    (),
        .fall    (pin_fall)
    );

    // =============================================================
    // Power-on reset pulse on the pin, then hand over to input
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt       <= 16'h0000;
            por_active    <= 1'b1;
            por_done      <= 1'b0;
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= 1'b1;
        end else begin
            por_active <= 1'b0;
            if (!por_done) begin
                if (por_cnt == POR_CYCLES[15:0] - 16'h0001) begin
                    por_done     <= 1'b1;
                    reset_pin_oe <= 1'b0;
                end else begin
                    por_cnt <= por_cnt + 16'h0001;
                end
            end
        end
    end

    // =============================================================
    // External reset timer: acts after pin held low the full delay
    wire ext_fire = por_done & ~pin_level & ~ext_done & (ext_cnt == EXT_CYCLES[15:0] - 16'h0001);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_cnt  <= 16'h0000;
            ext_done <= 1'b0;
        end else if (!por_done || pin_level || pin_fall) begin
            ext_cnt  <= 16'h0000;
            ext_done <= 1'b0;
        end else if (ext_fire) begin
            ext_done <= 1'b1;
        end else if (!ext_done) begin
            ext_cnt <= ext_cnt + 16'h0001;
        end
    end

    // =============================================================
    // Control, sleep and setup registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl        <= `CTRL_RESET;
            sleep_ctrl  <= `SLEEP_RESET;
            limit_reg   <= `LIMIT_RESET;
            setup_reg   <= `SETUP_RESET;
            sleep_mask  <= `MASK_RESET;
            other_mask  <= `MASK_RESET;
            factory_reg <= `FACTORY_RESET;
            wide_sel    <= 2'b00;
        end else begin
            if (wr_acc && off == `OFF_CTRL) begin
                ctrl <= {29'h0, pwdata[2:0]};
            end
            if (wr_acc && off == `OFF_SLEEP) begin
                sleep_ctrl <= pwdata[7:0];
            end
            if (cfg_wr && off == `OFF_LIMIT) begin
                limit_reg <= pwdata[7:0];
            end
            if (cfg_wr && off == `OFF_SETUP) begin
                setup_reg <= pwdata[7:0];
            end
            if (wr_acc && off == `OFF_SLEEP_MASK) begin
                sleep_mask <= pwdata[7:0];
            end
            if (wr_acc && off == `OFF_OTHER_MASK) begin
                other_mask <= pwdata[7:0];
            end
            if (wr_acc && off == `OFF_WIDE_SEL) begin
                wide_sel <= pwdata[1:0];
            end
            if (ext_fire) begin
                ctrl[`CTRL_LOCK_BIT] <= 1'b0;
                sleep_ctrl           <= `SLEEP_DEEP;
            end
        end
    end

    // =============================================================
    // Wide registers: frozen reads and buffered writes
    wire rd_lo = rd_acc && off == `OFF_WIDE_LO;
    wire rd_hi = rd_acc && off == `OFF_WIDE_HI;
    wire wr_lo = cfg_wr && off == `OFF_WIDE_LO;
    wire wr_hi = cfg_wr && off == `OFF_WIDE_HI;
    wire hi_ok = pend && pend_idx == wide_sel;

    integer k;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frozen     <= 1'b0;
            frozen_hi  <= 8'h00;
            frozen_idx <= 2'b00;
            pend       <= 1'b0;
            pend_lo    <= 8'h00;
            pend_idx   <= 2'b00;
            nack       <= 1'b0;
            for (k = 0; k < NUM_WIDE; k = k + 1) begin
                wide_val[k] <= 16'h0000;
            end
        end else begin
            if (rd_lo) begin
                frozen     <= 1'b1;
                frozen_hi  <= wide_val[wide_sel][15:8];
                frozen_idx <= wide_sel;
            end else if (rd_hi && frozen && frozen_idx == wide_sel) begin
                frozen <= 1'b0;
            end
            if (wr_lo) begin
                pend     <= 1'b1;
                pend_lo  <= pwdata[7:0];
                pend_idx <= wide_sel;
            end else if (wr_hi) begin
                pend <= pend & ~hi_ok;
                nack <= ~hi_ok;
                if (hi_ok) begin
                    wide_val[wide_sel] <= {pwdata[7:0], pend_lo};
                end
            end
        end
    end

    // =============================================================
    // Slave address strap, caught on the first bus transaction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_s1   <= 2'b00;
            strap_s2   <= 2'b00;
            acc_pipe   <= 2'b00;
            slave_addr <= `ADDR_STRAP_LOW;
            addr_fixed <= 1'b0;
        end else begin
            strap_s1 <= addr_strap;
            strap_s2 <= strap_s1;
            acc_pipe <= {acc_pipe[0], acc};
            if (acc_pipe[1] && !addr_fixed) begin // Delayed to match strap sync
                addr_fixed <= 1'b1;
                case (strap_s2)
                    2'b00: slave_addr <= `ADDR_STRAP_LOW;
                    2'b01: slave_addr <= `ADDR_STRAP_MID;
                    default: slave_addr <= `ADDR_STRAP_HIGH;
                endcase
            end
        end
    end

    // =============================================================
    // Round-robin conversion sequencer
    localparam CH_INT = 5'd0;
    localparam CH_1A  = 5'd1;
    localparam CH_1B  = 5'd2;
    localparam CH_2A  = 5'd3;
    localparam CH_2B  = 5'd4;
    localparam CH_AL  = 5'd20;
    localparam [31:0] SLOT_CYC = PASS_CYCLES / (`NUM_CHANNELS + 1);

    reg [4:0] next_channel;
    always @* begin
        case (conv_channel)
            CH_INT:  next_channel = CH_1A;
            CH_1A:   next_channel = diode_1b_en ? CH_1B : CH_2A;
            CH_1B:   next_channel = CH_2A;
            CH_2A:   next_channel = diode_2b_en ? CH_2B : 5'd5;
            CH_AL:   next_channel = CH_INT;
            default: next_channel = conv_channel + 5'd1;
        endcase
    end

    integer c;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pass_cnt     <= 32'h0000_0000;
            conv_channel <= CH_INT;
            conv_start   <= 1'b0;
            for (c = 0; c < `NUM_CHANNELS; c = c + 1) begin
                conv_val[c] <= 8'h00;
            end
        end else begin
            conv_start <= 1'b0;
            if (pass_cnt == SLOT_CYC - 32'h0000_0001) begin
                pass_cnt     <= 32'h0000_0000;
                conv_val[conv_channel] <= conv_data;
                conv_channel <= next_channel;
                conv_start   <= 1'b1;
            end else begin
                pass_cnt <= pass_cnt + 32'h0000_0001;
            end
        end
    end

    // =============================================================
    // Error status banks
    wire alert_std = ctrl[`CTRL_ALERT_STD];
    sticky_bank #(.WIDTH(8)) u_bmc_bank (
        .pclk      (pclk),
        .presetn   (presetn),
        .por_clear (por_active),
        .event_in  (bmc_event),
        .wr_clear  (wr_acc && off == `OFF_BMC_ERR),
        .wr_data   (pwdata[7:0]),
        .rd_clear  (alert_std && rd_acc && off == `OFF_BMC_ERR),
        .flags     (bmc_flags)
    );
    sticky_bank #(.WIDTH(8)) u_host_bank (
        .pclk      (pclk),
        .presetn   (presetn),
        .por_clear (por_active),
        .event_in  (host_event),
        .wr_clear  (wr_acc && off == `OFF_HOST_ERR),
        .wr_data   (pwdata[7:0]),
        .rd_clear  (1'b0),
        .flags     (host_flags)
    );

    // =============================================================
    // Read mux and bus answer
    reg [31:0] next_rdata;
    reg        next_err;
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (off)
            `OFF_CTRL:       next_rdata = ctrl;
            `OFF_STATUS:     next_rdata = {28'h0, por_done, frozen, pend, nack};
            `OFF_WIDE_LO:    next_rdata = {24'h0, wide_val[wide_sel][7:0]};
            `OFF_WIDE_HI:    next_rdata = {24'h0, (frozen && frozen_idx == wide_sel) ?
                                           frozen_hi : wide_val[wide_sel][15:8]};
            `OFF_WIDE_SEL:   next_rdata = {30'h0, wide_sel};
            `OFF_BMC_ERR:    next_rdata = {24'h0, bmc_flags};
            `OFF_HOST_ERR:   next_rdata = {24'h0, host_flags};
            `OFF_SLEEP:      next_rdata = {24'h0, sleep_ctrl};
            `OFF_SLAVE_ADDR: next_rdata = {24'h0, addr_fixed, slave_addr};
            `OFF_CONV:       next_rdata = {19'h0, conv_channel, conv_val[conv_channel]};
            `OFF_EVENT:      next_rdata = {16'h0, host_event, bmc_event};
            `OFF_LIMIT:      next_rdata = {24'h0, limit_reg};
            `OFF_SETUP:      next_rdata = {24'h0, setup_reg};
            `OFF_SLEEP_MASK: next_rdata = {24'h0, sleep_mask};
            `OFF_OTHER_MASK: next_rdata = {24'h0, other_mask};
            `OFF_FACTORY:    next_rdata = {24'h0, factory_reg};
            default:         next_err   = 1'b1;
        endcase
        if (wr_hi && !hi_ok) begin
            next_err = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc & next_err;
            if (rd_acc) begin
                prdata <= next_rdata;
            end
        end
    end
endmodule // monitor_regs

// *** design/monitor_map.vh ***
// Register offsets, field positions, reset values and timing counts for the monitor block
`ifndef MONITOR_MAP_VH
`define MONITOR_MAP_VH

// =============================================================
// Register byte offsets
`define OFF_CTRL          12'h000
`define OFF_STATUS        12'h004
`define OFF_WIDE_LO       12'h008
`define OFF_WIDE_HI       12'h00C
`define OFF_WIDE_SEL      12'h010
`define OFF_BMC_ERR       12'h014
`define OFF_HOST_ERR      12'h018
`define OFF_SLEEP         12'h01C
`define OFF_SLAVE_ADDR    12'h020
`define OFF_CONV          12'h024
`define OFF_EVENT         12'h028
`define OFF_LIMIT         12'h02C
`define OFF_SETUP         12'h030
`define OFF_SLEEP_MASK    12'h034
`define OFF_OTHER_MASK    12'h038
`define OFF_FACTORY       12'h03C

// =============================================================
// Control register fields
`define CTRL_LOCK_BIT     0
`define CTRL_GLOBAL_ERROR_MASK_BIT_BIT     1
`define CTRL_ALERT_STD    2
`define CTRL_RESET        32'h0000_0002

// =============================================================
// Status register fields
`define STAT_NACK_BIT     0
`define STAT_PEND_BIT     1
`define STAT_FROZEN_BIT   2
`define STAT_POR_BIT      3

// =============================================================
// Reset values
`define SLEEP_DEEP        8'h05
`define SLEEP_RESET       8'h00
`define LIMIT_RESET       8'hFF
`define SETUP_RESET       8'h00
`define MASK_RESET        8'h00
`define FACTORY_RESET     8'h00

// =============================================================
// Slave addresses chosen by the strap
`define ADDR_STRAP_LOW    7'h2C
`define ADDR_STRAP_MID    7'h2E
`define ADDR_STRAP_HIGH   7'h2D

// =============================================================
// Timing
`define CLK_MHZ           50
`define EXT_RESET_NS      10000
`define EXT_RESET_CYC     ((`EXT_RESET_NS * `CLK_MHZ) / 1000)
`define POR_PULSE_NS      20000
`define POR_PULSE_CYC     ((`POR_PULSE_NS * `CLK_MHZ) / 1000)
`define PASS_MS           100
`define PASS_CYC          (`PASS_MS * 1000 * `CLK_MHZ)
`define NUM_CHANNELS      21
`define NUM_WIDE          4

`endif

// *** design/edge_sync.v ***
// Two-stage synchroniser with rise and fall detection
module edge_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire din,
    output reg  level,
    output wire rise,
    output wire fall
);
    reg stage1;
    reg stage2;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            level  <= 1'b1;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            level  <= stage2;
        end
    end

    assign rise = stage2 & ~level;
    assign fall = ~stage2 & level;
endmodule // edge_sync

// *** design/sticky_bank.v ***
// One bank of sticky error bits with write-1-clear and optional read-clear
module sticky_bank #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             por_clear,
    input  wire [WIDTH-1:0] event_in,
    input  wire             wr_clear,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             rd_clear,
    output reg  [WIDTH-1:0] flags
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            wire clr;
            assign clr = (wr_clear & wr_data[i]) | rd_clear;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flags[i] <= 1'b0;
                end else if (por_clear) begin
                    flags[i] <= 1'b0;
                end else if (event_in[i]) begin
                    // Live event keeps bit set, beats write and read clears but not the power-on clear
                    flags[i] <= 1'b1;
                end else if (clr) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // sticky_bank

// *** sim/monitor_regs_asserts.sv ***
// Port-level checker for the monitor register block
module monitor_regs_asserts #(
    parameter PASS_CYCLES = 2200
) (
    input wire       pclk,
    input wire       presetn,
    input wire       psel,
    input wire       penable,
    input wire       pready,
    input wire       reset_pin_out,
    input wire       reset_pin_oe,
    input wire [4:0] conv_channel,
    input wire       conv_start
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POR_MAX = 40;
    int busy_cnt;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =========================================
    // Cycles spent away from the first channel
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            busy_cnt <= 0;
        else if (conv_channel == 5'h00)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_cnt + 1;
    end
    // =========================================
    // Properties
    AST_POR_DRIVE: assert property ($rose(presetn) |-> reset_pin_oe)
        else $error("pin not driven after power-on");
    AST_POR_RELEASE: assert property ($rose(presetn) |-> ##[1:POR_MAX] !reset_pin_oe)
        else $error("power-on pulse never ends");
    AST_PIN_LOW: assert property (reset_pin_oe |-> !reset_pin_out)
        else $error("pin driven high");
    AST_PIN_INPUT: assert property ($fell(reset_pin_oe) |-> !reset_pin_oe [*8])
        else $error("pin driven again after power-on");
    AST_READY: assert property (psel && !penable |=> pready && penable)
        else $error("no answer in access phase");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_START_PULSE: assert property (conv_start |=> !conv_start [*8])
        else $error("conversion steps too close");
    AST_CHAN_RANGE: assert property (conv_channel <= 5'h14)
        else $error("channel out of range");
    AST_CHAN_ORDER: assert property ($changed(conv_channel) |->
        ((conv_channel == 5'h00) ? ($past(conv_channel) == 5'h14)
                                 : (conv_channel > $past(conv_channel))))
        else $error("channel order broken");
    AST_PASS_TIME: assert property (busy_cnt < PASS_CYCLES)
        else $error("pass too long");
endmodule // monitor_regs_asserts

bind monitor_regs monitor_regs_asserts #(.PASS_CYCLES(PASS_CYCLES)) monitor_regs_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
    .conv_channel(conv_channel), .conv_start(conv_start));

// *** sim/reset_driver.sv ***
// External reset driver on the open-drain reset pin
module reset_driver #(
    parameter int HOLD = 30
) (
    input  wire  pclk,
    input  wire  dev_oe,
    input  wire  dev_out,
    input  wire  req,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    // Pulled up, so the pin never floats
    assign pin = ((dev_oe && !dev_out) || cnt != 0) ? 1'b0 : 1'b1;
    // Holds the pin low well past detection time
    always @(posedge pclk) begin
        if (req && cnt == 0)
            cnt <= HOLD;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule // reset_driver

// *** sim/tb_monitor_regs.sv ***
// Self-checking bench for the monitor register block
`include "monitor_map.vh"
module tb_monitor_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rst_req = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, pin, pin_out, pin_oe, conv_start, last_err;
    logic [1:0] addr_strap = 2'h1;
    logic [7:0] bmc_event = 0, host_event = 0, conv_data = 8'h5A;
    logic [4:0] conv_channel;
    logic diode_1b_en = 1'b1, diode_2b_en = 1'b0;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    always #10 pclk = ~pclk;
    monitor_regs #(.PASS_CYCLES(2200), .EXT_CYCLES(20), .POR_CYCLES(10)) monitor_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_pin_in(pin), .reset_pin_out(pin_out),
        .reset_pin_oe(pin_oe), .addr_strap(addr_strap), .bmc_event(bmc_event),
        .host_event(host_event), .conv_data(conv_data), .diode_1b_en(diode_1b_en),
        .diode_2b_en(diode_2b_en), .conv_channel(conv_channel), .conv_start(conv_start));
    reset_driver #(.HOLD(30)) reset_driver_inst (
        .pclk(pclk), .dev_oe(pin_oe), .dev_out(pin_out), .req(rst_req), .pin(pin));
    // =========================================
    // Helpers
    task automatic conclude();
        if (error_cnt == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // Single master, so bus accesses never overlap
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) chk(32'h0, 32'h1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk({24'h0, q[7:0]}, {24'h0, e});
    endtask
    // =========================================
    // Scenarios
    task automatic t_strap();
        apb(1'b0, `OFF_SLAVE_ADDR, 32'h0);
        rdc(`OFF_SLAVE_ADDR, {1'b1, `ADDR_STRAP_MID});
        addr_strap <= 2'h3;
        repeat (4) @(posedge pclk);
        rdc(`OFF_SLAVE_ADDR, {1'b1, `ADDR_STRAP_MID});
    endtask
    task automatic t_reset_vals();
        logic [11:0] a [8];
        a = '{`OFF_LIMIT, `OFF_SETUP, `OFF_SLEEP, `OFF_SLEEP_MASK, `OFF_OTHER_MASK,
              `OFF_FACTORY, `OFF_BMC_ERR, `OFF_HOST_ERR};
        apb(1'b0, `OFF_CTRL, 32'h0);
        chk(q, `CTRL_RESET);
        foreach (a[i]) rdc(a[i], (i == 0) ? `LIMIT_RESET : 8'h00);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, last_err}, 32'h1);
    endtask
    task automatic t_wide_wr();
        wr(`OFF_WIDE_SEL, 8'h00); wr(`OFF_WIDE_LO, 8'h22); wr(`OFF_WIDE_HI, 8'h11);
        chk({31'h0, last_err}, 32'h0);
        wr(`OFF_WIDE_HI, 8'h77);
        chk({31'h0, last_err}, 32'h1);
        rdc(`OFF_STATUS, 8'h09);
        wr(`OFF_WIDE_LO, 8'hAA);
        rdc(`OFF_WIDE_LO, 8'h22);
        wr(`OFF_WIDE_SEL, 8'h01); wr(`OFF_WIDE_LO, 8'h55);
        wr(`OFF_WIDE_SEL, 8'h00); wr(`OFF_WIDE_HI, 8'h77);
        chk({31'h0, last_err}, 32'h1);
        rdc(`OFF_WIDE_LO, 8'h22);
        rdc(`OFF_WIDE_HI, 8'h11);
        wr(`OFF_WIDE_SEL, 8'h01); wr(`OFF_WIDE_HI, 8'h66);
        chk({31'h0, last_err}, 32'h0);
    endtask
    task automatic t_wide_rd();
        rdc(`OFF_WIDE_LO, 8'h55);
        wr(`OFF_WIDE_LO, 8'h99); wr(`OFF_WIDE_HI, 8'h88);
        rdc(`OFF_WIDE_HI, 8'h66);
        rdc(`OFF_WIDE_HI, 8'h88);
        rdc(`OFF_WIDE_LO, 8'h99);
        wr(`OFF_WIDE_SEL, 8'h00);
        rdc(`OFF_WIDE_LO, 8'h22);
        wr(`OFF_WIDE_SEL, 8'h01); wr(`OFF_WIDE_LO, 8'h01); wr(`OFF_WIDE_HI, 8'h02);
        rdc(`OFF_WIDE_HI, 8'h02);
    endtask
    task automatic t_ext_reset();
        wr(`OFF_LIMIT, 8'h11); wr(`OFF_CTRL, 8'h01);
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk({31'h0, q[`STAT_POR_BIT]}, 32'h1);
        rst_req <= 1'b1;
        @(posedge pclk);
        rst_req <= 1'b0;
        repeat (6) @(posedge pclk);
        rdc(`OFF_CTRL, 8'h01);
        repeat (30) @(posedge pclk);
        rdc(`OFF_CTRL, 8'h00);
        rdc(`OFF_SLEEP, `SLEEP_DEEP);
        rdc(`OFF_LIMIT, 8'h11);
    endtask
    task automatic t_err_banks();
        bmc_event <= 8'h03; host_event <= 8'h01;
        repeat (2) @(posedge pclk);
        bmc_event <= 8'h02; host_event <= 8'h00;
        @(posedge pclk);
        rdc(`OFF_BMC_ERR, 8'h03);
        wr(`OFF_BMC_ERR, 8'h00);
        rdc(`OFF_BMC_ERR, 8'h03);
        wr(`OFF_BMC_ERR, 8'h03);
        rdc(`OFF_BMC_ERR, 8'h02);
        rdc(`OFF_HOST_ERR, 8'h01);
        bmc_event <= 8'h00;
        wr(`OFF_CTRL, 8'h04);
        rdc(`OFF_BMC_ERR, 8'h02);
        rdc(`OFF_BMC_ERR, 8'h00);
        rdc(`OFF_HOST_ERR, 8'h01);
        wr(`OFF_HOST_ERR, 8'h01);
        rdc(`OFF_HOST_ERR, 8'h00);
    endtask
    task automatic t_scan(input logic b1, input logic b2);
        logic [4:0] exp [$];
        logic [4:0] prev;
        int n;
        diode_1b_en <= b1;
        diode_2b_en <= b2;
        exp = {5'h01};
        if (b1) exp.push_back(5'h02);
        exp.push_back(5'h03);
        if (b2) exp.push_back(5'h04);
        for (int i = 5; i <= 20; i++) exp.push_back(5'(i));
        exp.push_back(5'h00);
        n = 0;
        prev = conv_channel;
        while (!(conv_channel === 5'h00 && prev !== 5'h00) && n < 3000) begin
            prev = conv_channel;
            @(posedge pclk);
            n++;
        end
        n = 0;
        foreach (exp[i]) begin
            prev = conv_channel;
            while (conv_channel === prev && n < 3000) begin
                @(posedge pclk);
                n++;
            end
            chk({27'h0, conv_channel}, {27'h0, exp[i]});
        end
        chk(32'(n < 2200), 32'h1);
        rdc(`OFF_CONV, 8'h5A);
    endtask
    // =========================================
    // Main sequence and hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_strap();
        t_reset_vals();
        t_wide_wr();
        t_wide_rd();
        t_ext_reset();
        t_err_banks();
        t_scan(1'b1, 1'b0);
        t_scan(1'b0, 1'b1);
        conclude();
    end
endmodule // tb_monitor_regs
